// [dv/act_clk_src.sv]
// model of the external crystal / clock source feeding the counter
`timescale 1ns/1ns
module act_clk_src (
	input wire logic run,
	output logic ext_clk
);
	// 160 ns period, stands still while stopped
	initial begin
		ext_clk = 1'b0;
		forever begin
			#80;
			ext_clk = run ? ~ext_clk : ext_clk;
		end
	end
endmodule

// [dv/act_timer_tb.sv]
// self-checking bench for the async counter/timer
`timescale 1ns/1ns
module act_timer_tb;
	import act_pkg::*;
	logic clk_sys, resetn, reg_wr, reg_rd, sleep_in, run, ext_clk, pin_in;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, delta;
	logic pin4_out, pin4_oe, pin5_out, pin5_oe, osc_enable, irq, wake, isr_req;
	logic [15:0] v;
	int error_cnt, check_count, seed, i;
	act_timer u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_clk_in(ext_clk), .sleep_in(sleep_in), .pin4_in(pin_in), .pin5_in(pin_in),
		.pin4_out(pin4_out), .pin4_oe(pin4_oe), .pin5_out(pin5_out), .pin5_oe(pin5_oe),
		.osc_enable(osc_enable), .irq(irq), .wake(wake), .isr_req(isr_req));
	act_clk_src u_src (.run(run), .ext_clk(ext_clk));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		q = reg_rdata;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// pins under the oscillator read as zero
	function automatic logic [7:0] pin_exp(input logic osc, input logic [7:0] val);
		return osc ? 8'h00 : val;
	endfunction
	// internal source: one tick per 4 clocks, divided by the prescaler
	function automatic logic [7:0] int_exp(input logic [1:0] ps, input int cycles);
		return 8'((cycles / 4) >> ps);
	endfunction
	initial begin
		seed = 32'hD36F9BA0;
		{resetn, reg_wr, reg_rd, sleep_in, run} = 5'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		pin_in = 1'b1;
		error_cnt = 0;
		check_count = 0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(ACT_OFS_INTCTL, d); chk("intctl", d, 16'h0000);
		rd(ACT_OFS_FLAGS, d); chk("flags", d, 16'h0000);
		rd(ACT_OFS_CTRL, d); chk("ctrl", d, 16'h0000);
		rd(ACT_OFS_ENABLES, d); chk("enables", d, 16'h0000);
		rd(8'h40, d); chk("unmapped", d, 16'h0000);
		// count survives a reset while the counter is stopped
		for (int k = 0; k < 3; k++) begin
			v = 16'($random(seed));
			wr(ACT_OFS_CNT_LO, v[7:0]);
			wr(ACT_OFS_CNT_HI, v[15:8]);
			@(posedge clk_sys);
			resetn <= 1'b0;
			repeat (2) @(posedge clk_sys);
			resetn <= 1'b1;
			rd(ACT_OFS_CNT_LO, d); chk("cnt_lo", d, v[7:0]);
			rd(ACT_OFS_CNT_HI, d); chk("cnt_hi", d, v[15:8]);
		end
		wr(ACT_OFS_PIN_DIR, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("oe_out", pin4_oe & pin5_oe, 16'h0001);
		wr(ACT_OFS_PIN_DATA, 8'h10);
		@(posedge clk_sys);
		chk("pin_out", {pin5_out, pin4_out}, 16'h0001);
		rd(ACT_OFS_PIN_DATA, d); chk("pins_free", d & 8'h30, pin_exp(1'b0, 8'h30));
		wr(ACT_OFS_CTRL, 8'h08);
		run <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk("osc_en", osc_enable, 16'h0001);
		chk("oe_osc", pin4_oe | pin5_oe, 16'h0000);
		wr(ACT_OFS_PIN_DIR, 8'h00);
		rd(ACT_OFS_PIN_DIR, d); chk("dir", d & 8'h30, 16'h0030);
		rd(ACT_OFS_PIN_DATA, d); chk("pins", d & 8'h30, pin_exp(1'b1, 8'h30));
		wr(ACT_OFS_ENABLES, 8'h01);
		wr(ACT_OFS_INTCTL, 8'h40);
		wr(ACT_OFS_CNT_LO, 8'hFE);
		wr(ACT_OFS_CNT_HI, 8'hFF);
		sleep_in <= 1'b1;
		wr(ACT_OFS_CTRL, 8'h0F);
		for (i = 0; i < 500 && wake !== 1'b1; i++)
			@(posedge clk_sys);
		chk("wake", wake, 16'h0001);
		if (wake !== 1'b1)
			give_verdict();
		chk("irq", irq, 16'h0001);
		chk("isr_off", isr_req, 16'h0000);
		rd(ACT_OFS_FLAGS, d); chk("flag", d[0], 16'h0001);
		rd(ACT_OFS_CNT_HI, d); chk("cnt_wrap", d, 16'h0000);
		wr(ACT_OFS_INTCTL, 8'hC0);
		repeat (3) @(posedge clk_sys);
		chk("isr_on", isr_req, 16'h0001);
		wr(ACT_OFS_ENABLES, 8'h00);
		repeat (3) @(posedge clk_sys);
		chk("irq_mask", irq | wake, 16'h0000);
		wr(ACT_OFS_ENABLES, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk("irq_unmask", irq, 16'h0001);
		wr(ACT_OFS_FLAGS, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk("irq_clr", irq, 16'h0000);
		// synchronous mode must stall while asleep
		wr(ACT_OFS_CTRL, 8'h08);
		wr(ACT_OFS_CNT_LO, 8'h34);
		wr(ACT_OFS_CNT_HI, 8'h12);
		wr(ACT_OFS_CTRL, 8'h0B);
		repeat (100) @(posedge clk_sys);
		rd(ACT_OFS_CNT_LO, d); chk("sync_sleep", d, 16'h0034);
		// awake again: pending and new edges are counted on phase ticks
		@(posedge clk_sys);
		sleep_in <= 1'b0;
		repeat (64) @(posedge clk_sys);
		rd(ACT_OFS_CNT_LO, d);
		delta = d - 8'h34;
		chk("sync_wake", 16'(delta >= 8'h03 && delta <= 8'h06), 16'h0001);
		wr(ACT_OFS_CTRL, 8'h00);
		// internal source, every prescale: 64 enabled edges give 16 ticks
		for (int k = 0; k < 4; k++) begin
			wr(ACT_OFS_CNT_LO, 8'h00);
			wr(ACT_OFS_CNT_HI, 8'h00);
			wr(ACT_OFS_CTRL, {2'b00, 2'(k), 4'h1});
			repeat (62) @(posedge clk_sys);
			wr(ACT_OFS_CTRL, 8'h00);
			rd(ACT_OFS_CNT_LO, d); chk("int_cnt", d, int_exp(2'(k), 64));
		end
		give_verdict();
	end
endmodule

// [verilog/act_pkg.sv]
// package: register map, field positions and reset values of the counter/timer
package act_pkg;

	localparam logic [7:0] ACT_OFS_INTCTL = 8'h0B;
	localparam logic [7:0] ACT_OFS_FLAGS = 8'h0C;
	localparam logic [7:0] ACT_OFS_CNT_LO = 8'h0E;
	localparam logic [7:0] ACT_OFS_CNT_HI = 8'h0F;
	localparam logic [7:0] ACT_OFS_CTRL = 8'h10;
	localparam logic [7:0] ACT_OFS_ENABLES = 8'h8C;
	localparam logic [7:0] ACT_OFS_PIN_DATA = 8'h05;
	localparam logic [7:0] ACT_OFS_PIN_DIR = 8'h85;

	localparam int ACT_BIT_GIE = 7;
	localparam int ACT_BIT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int ACT_BIT_OVF = 0;
	localparam int ACT_BIT_PIN4 = 4;
	localparam int ACT_BIT_PIN5 = 5;

	localparam logic [7:0] ACT_INTCTL_RST = 8'h00;
	localparam logic [7:0] ACT_CTRL_RST = 8'h00;
	localparam logic ACT_FLAG_RST = 1'h0;
	localparam logic ACT_ENABLE_RST = 1'h0;
	localparam logic [1:0] ACT_PIN_DIR_RST = 2'h3;
	localparam logic [1:0] ACT_PIN_OUT_RST = 2'h0;
	localparam logic [7:0] ACT_RDATA_RST = 8'h00;

	// internal phase clock: one count tick per instruction cycle
	localparam logic [1:0] ACT_PHASE_LAST = 2'h3;

	typedef struct packed {
		logic rsvd;
		logic gate_enable;
		logic [1:0] prescale;
		logic timer_osc_enable;
		logic sync_bypass;
		logic count_source_select;
		logic timer_on;
	} act_ctrl_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} act_bus_type;

endpackage

// [verilog/act_timer.sv]
// 16-bit async counter/timer with crystal enable, pin override and wake logic
`timescale 1ns/1ns

// Notes on behaviour
// RQ1: bypass bit counts external edges without phase alignment
// RQ2: async mode counts through sleep, overflow wakes
// RQ3: count byte reads return a stable value
// RQ4: software stops counter before writing count
// RQ5: osc enable bit turns on crystal oscillator
// RQ6: crystal only usable with internal system clock
// RQ7: osc enabled forces pins 4,5 to input
// RQ8: software waits for oscillator start before counting
// RQ9: sleep counting only in async external mode
// RQ10: wake when on, overflow enable, peripheral enable
// RQ11: global enable also requests the service routine
// RQ12: count bytes not reset, keep through resets
// RQ13: rollover sets sticky overflow flag
module act_timer
	import act_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_clk_in,
	input wire logic sleep_in,
	input wire logic pin4_in,
	input wire logic pin5_in,
	output logic pin4_out,
	output logic pin4_oe,
	output logic pin5_out,
	output logic pin5_oe,
	output logic osc_enable,
	output logic irq,
	output logic wake,
	output logic isr_req
);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	function automatic logic [2:0] pre_mask(input logic [1:0] ps);
		pre_mask = 3'((4'h1 << ps) - 4'h1);
	endfunction

	function automatic logic hit(input act_bus_type b, input logic [7:0] ofs);
		hit = b.wr && (b.addr == ofs);
	endfunction

	act_bus_type bus;
	act_ctrl_type ctrl_r;
	logic [7:0] intctl_r;
	logic flag_r;
	logic ie_r;
	logic [15:0] count_r;
	logic [1:0] dir_r;
	logic [1:0] pin_out_r;
	logic [1:0] phase_r;
	logic [2:0] pre_r;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic pend_r;
	logic [7:0] rdata_r;
	logic irq_r;
	logic wake_r;
	logic isr_r;
	logic osc_r;
	logic [1:0] oe_r;
	logic phase_tick;
	logic ext_rise;
	logic async_mode;
	logic src_evt;
	logic inc;
	logic ovf;
	logic cnt_wr;
	logic wake_cond;
	logic [1:0] pin_rd;
	logic flag_clr;

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// input synchronisers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			pin_s1_r <= 2'b00;
			pin_s2_r <= 2'b00;
		end else begin
			ext_s1_r <= ext_clk_in;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			pin_s1_r <= {pin5_in, pin4_in};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign ext_rise = ext_s2_r && !ext_s3_r;

	// internal phase clock stops while the core sleeps
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_r <= 2'b00;
		end else if (!sleep_in) begin
			phase_r <= phase_r + 2'b01;
		end
	end

	assign phase_tick = !sleep_in && (phase_r == ACT_PHASE_LAST);

	// synchronous mode: an edge waits for the next phase tick
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend_r <= 1'b0;
		end else if (ext_rise) begin
			pend_r <= 1'b1;
		end else if (phase_tick) begin
			pend_r <= 1'b0;
		end
	end

	assign async_mode = ctrl_r.timer_on && ctrl_r.count_source_select && ctrl_r.sync_bypass;

	always_comb begin
		src_evt = 1'b0;
		if (ctrl_r.timer_on) begin
			if (!ctrl_r.count_source_select) begin
				src_evt = phase_tick;
			end else if (ctrl_r.sync_bypass) begin
				src_evt = ext_rise; // [RQ1] [RQ2] [RQ9]
			end else begin
				src_evt = pend_r && phase_tick; // [RQ9]
			end
		end
	end

	assign cnt_wr = hit(bus, ACT_OFS_CNT_LO) || hit(bus, ACT_OFS_CNT_HI);
	assign inc = src_evt && ((pre_r & pre_mask(ctrl_r.prescale)) == pre_mask(ctrl_r.prescale));
	assign ovf = inc && !cnt_wr && (count_r == 16'hFFFF);

	// prescaler, cleared by any count write
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pre_r <= 3'b000;
		end else if (cnt_wr) begin
			pre_r <= 3'b000;
		end else if (src_evt) begin
			pre_r <= inc ? 3'b000 : pre_r + 3'b001;
		end
	end

	// count holds its value through reset; unknown until written
	always_ff @(posedge clk_sys) begin
		if (hit(bus, ACT_OFS_CNT_LO)) begin // [RQ12]
			count_r[7:0] <= bus.wdata; // [RQ4]
		end else if (hit(bus, ACT_OFS_CNT_HI)) begin
			count_r[15:8] <= bus.wdata;
		end else if (inc) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// control, interrupt control and enables
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= ACT_CTRL_RST;
			intctl_r <= ACT_INTCTL_RST;
			ie_r <= ACT_ENABLE_RST;
		end else begin
			if (hit(bus, ACT_OFS_CTRL)) begin
				ctrl_r <= {1'b0, bus.wdata[6:0]};
			end
			if (hit(bus, ACT_OFS_INTCTL)) begin
				intctl_r <= bus.wdata;
			end
			if (hit(bus, ACT_OFS_ENABLES)) begin
				ie_r <= bus.wdata[ACT_BIT_OVF];
			end
		end
	end

	assign flag_clr = hit(bus, ACT_OFS_FLAGS) && bus.wdata[ACT_BIT_OVF];

	// sticky overflow flag, write one to clear, set wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			flag_r <= ACT_FLAG_RST;
		end else if (ovf) begin
			flag_r <= 1'b1; // [RQ13]
		end else if (flag_clr) begin
			flag_r <= 1'b0;
		end
	end

	assign wake_cond = flag_r && ie_r && intctl_r[ACT_BIT_PERIPHERAL_IRQ_ENABLE] && ctrl_r.timer_on;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			isr_r <= 1'b0;
		end else begin
			irq_r <= flag_r && ie_r;
			wake_r <= wake_cond; // [RQ10] [RQ2]
			isr_r <= wake_cond && intctl_r[ACT_BIT_GIE]; // [RQ11]
		end
	end

	// pins 4 and 5: oscillator overrides direction and data
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dir_r <= ACT_PIN_DIR_RST;
			pin_out_r <= ACT_PIN_OUT_RST;
		end else begin
			if (ctrl_r.timer_osc_enable) begin
				dir_r <= 2'b11; // [RQ7]
			end else if (hit(bus, ACT_OFS_PIN_DIR)) begin
				dir_r <= bus.wdata[ACT_BIT_PIN5:ACT_BIT_PIN4];
			end
			if (hit(bus, ACT_OFS_PIN_DATA)) begin
				pin_out_r <= bus.wdata[ACT_BIT_PIN5:ACT_BIT_PIN4];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			osc_r <= 1'b0;
			oe_r <= 2'b00;
		end else begin
			osc_r <= ctrl_r.timer_osc_enable; // [RQ5]
			oe_r <= ~dir_r & {2{!ctrl_r.timer_osc_enable}}; // [RQ7]
		end
	end

	assign pin_rd = ctrl_r.timer_osc_enable ? 2'b00 : pin_s2_r; // [RQ7]

	// read port, data in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= ACT_RDATA_RST;
		end else if (bus.rd) begin
			unique case (bus.addr)
				ACT_OFS_INTCTL: rdata_r <= intctl_r;
				ACT_OFS_FLAGS: rdata_r <= {7'h00, flag_r};
				ACT_OFS_CNT_LO: rdata_r <= count_r[7:0]; // [RQ3]
				ACT_OFS_CNT_HI: rdata_r <= count_r[15:8]; // [RQ3]
				ACT_OFS_CTRL: rdata_r <= ctrl_r;
				ACT_OFS_ENABLES: rdata_r <= {7'h00, ie_r};
				ACT_OFS_PIN_DATA: rdata_r <= {2'b00, pin_rd, 4'h0};
				ACT_OFS_PIN_DIR: rdata_r <= {2'b00, dir_r, 4'h0};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;
	assign pin4_out = pin_out_r[0];
	assign pin5_out = pin_out_r[1];
	assign pin4_oe = oe_r[0];
	assign pin5_oe = oe_r[1];
	assign osc_enable = osc_r;
	assign irq = irq_r;
	assign wake = wake_r;
	assign isr_req = isr_r;

	AST_ASYNC_EDGE_COUNTS: assert property ( // [RQ1]
		async_mode && ctrl_r.prescale == 2'b00 && ext_rise && !cnt_wr
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("async edge did not advance count");

	AST_SLEEP_HOLDS: assert property ( // [RQ9]
		sleep_in && !async_mode && !cnt_wr |=> $stable(count_r))
		else $error("count moved in sleep outside async mode");

	AST_SLEEP_ASYNC_RUNS: assert property ( // [RQ2]
		sleep_in && async_mode && ctrl_r.prescale == 2'b00 && ext_rise && !cnt_wr
		|=> !$stable(count_r))
		else $error("async count stalled in sleep");

	AST_READ_LOW: assert property ( // [RQ3]
		bus.rd && bus.addr == ACT_OFS_CNT_LO |=> reg_rdata == $past(count_r[7:0]))
		else $error("count low read wrong");

	AST_OSC_EN: assert property ( // [RQ5]
		ctrl_r.timer_osc_enable |=> osc_enable)
		else $error("oscillator not enabled");

	AST_PINS_FORCED: assert property ( // [RQ7]
		ctrl_r.timer_osc_enable && $past(ctrl_r.timer_osc_enable)
		|=> !pin4_oe && !pin5_oe && dir_r == 2'b11)
		else $error("pins not forced to input");

	AST_WAKE: assert property ( // [RQ10]
		flag_r && ie_r && intctl_r[ACT_BIT_PERIPHERAL_IRQ_ENABLE] && ctrl_r.timer_on |=> wake)
		else $error("no wake on overflow");

	AST_ISR: assert property ( // [RQ11]
		wake_cond && intctl_r[ACT_BIT_GIE] |=> isr_req && wake)
		else $error("no service request");

	AST_OVF_FLAG: assert property ( // [RQ13]
		ovf |=> flag_r ##1 (flag_r || $past(flag_clr)))
		else $error("overflow flag lost");

	AST_READ_HIGH: assert property ( // [RQ3]
		bus.rd && bus.addr == ACT_OFS_CNT_HI |=> reg_rdata == $past(count_r[15:8]))
		else $error("count high read wrong");

	AST_RDATA_IDLE: assert property ( // [RQ3]
		!bus.rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	AST_SYNC_WAITS_TICK: assert property ( // [RQ9]
		ctrl_r.timer_on && ctrl_r.count_source_select && !ctrl_r.sync_bypass
		&& !phase_tick && !cnt_wr |=> $stable(count_r))
		else $error("sync count moved off a phase tick");

	AST_PIN_READ_ZERO: assert property ( // [RQ7]
		bus.rd && bus.addr == ACT_OFS_PIN_DATA && ctrl_r.timer_osc_enable
		|=> reg_rdata == 8'h00)
		else $error("pins under oscillator read nonzero");

	AST_IRQ_SET: assert property ( // [RQ2]
		flag_r && ie_r |=> irq)
		else $error("interrupt not raised");

	AST_IRQ_MASKED: assert property ( // [RQ2]
		!(flag_r && ie_r) |=> !irq)
		else $error("interrupt raised while masked or clear");

	AST_NO_WAKE: assert property ( // [RQ10]
		!wake_cond |=> !wake && !isr_req)
		else $error("wake without its enables");

	AST_ISR_NEEDS_GLOBAL: assert property ( // [RQ11]
		!intctl_r[ACT_BIT_GIE] |=> !isr_req)
		else $error("service request without global enable");

	AST_FLAG_CLEAR: assert property ( // [RQ13]
		flag_clr && !ovf |=> !flag_r)
		else $error("overflow flag not cleared");

endmodule
